// ==== rfa_synth_base_word_addr_cfg.sv ====
// rfa_synth_base_word_addr_cfg: node address, channel, intermediate offset, trim and
// synthesizer base word registers, plus the derived synthesizer word.
// assumes: the serial port front end delivers one-cycle rd/wr strobes and
// the modem supplies channel spacing in base-word units.
`timescale 1ns/10ps
module rfa_synth_base_word_addr_cfg #(
  parameter int unsigned SPACING_W = 16
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // register port
  input  wire rfa_pkg::rfa_reg_req_t reg_req,
  output logic [7:0]                 reg_rdata,
  output logic                       reg_rvalid,
  // modem context
  input  wire logic                  rx_active,
  input  wire logic [SPACING_W-1:0]  slot_spacing,
  input  wire rfa_pkg::rfa_rx_addr_t rx_addr,
  // address verdict
  output logic                       addr_ok,
  output logic                       addr_ok_valid,
  // synthesizer and mixer
  output logic [23:0]                synth_word,
  output logic [4:0]                 mixer_if_word,
  output logic [1:0]                 filter_select,
  output logic [7:0]                 packet_automation_control
);
  import rfa_pkg::*;

  // register storage
  logic [7:0] filter_control;
  logic [7:0] node_match_value;
  logic [7:0] rf_slot_select;
  logic [7:0] synth_control_if;
  logic [7:0] synth_control_trim;
  logic [7:0] synth_base_high_byte;
  logic [7:0] synth_base_mid_byte;
  logic [7:0] synth_base_low_byte;
  logic [7:0] pkt_auto;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // write decode
  wire wr_filter = reg_req.wr & hit(reg_req.addr, OFS_FILTER_CTRL);
  wire wr_pkt    = reg_req.wr & hit(reg_req.addr, OFS_PKT_AUTO);
  wire wr_node   = reg_req.wr & hit(reg_req.addr, OFS_NODE_MATCH);
  wire wr_slot   = reg_req.wr & hit(reg_req.addr, OFS_SLOT_SEL);
  wire wr_if     = reg_req.wr & hit(reg_req.addr, OFS_CTRL_IF);
  wire wr_trim   = reg_req.wr & hit(reg_req.addr, OFS_CTRL_TRIM);
  wire wr_high   = reg_req.wr & hit(reg_req.addr, OFS_BASE_HIGH);
  wire wr_mid    = reg_req.wr & hit(reg_req.addr, OFS_BASE_MID);
  wire wr_low    = reg_req.wr & hit(reg_req.addr, OFS_BASE_LOW);

  // one short block per register; a write lands at its taking edge
  // filter control; only the mode bits are kept
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      filter_control <= RST_FILTER_CTRL;
    end else if (wr_filter) begin
      filter_control <= reg_req.wdata & MSK_FILTER_CTRL;
    end
  end

  // packet automation copy; reserved bits dropped
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pkt_auto <= RST_PKT_AUTO;
    end else if (wr_pkt) begin
      pkt_auto <= reg_req.wdata & MSK_PKT_AUTO;
    end
  end

  // node address, full byte
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      node_match_value <= RST_NODE_MATCH;
    end else if (wr_node) begin
      node_match_value <= reg_req.wdata;
    end
  end

  // slot index, unsigned
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rf_slot_select <= RST_SLOT_SEL;
    end else if (wr_slot) begin
      rf_slot_select <= reg_req.wdata;
    end
  end

  // offset word; upper bits never stored
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      synth_control_if <= RST_CTRL_IF;
    end else if (wr_if) begin
      synth_control_if <= reg_req.wdata & MSK_CTRL_IF;
    end
  end

  // trim stored raw; the sign only matters in the arithmetic
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      synth_control_trim <= RST_CTRL_TRIM;
    end else if (wr_trim) begin
      synth_control_trim <= reg_req.wdata;
    end
  end

  // base high byte; top two bits never stored
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      synth_base_high_byte <= RST_BASE_HIGH;
    end else if (wr_high) begin
      synth_base_high_byte <= reg_req.wdata & MSK_BASE_HIGH;
    end
  end

  // base middle byte
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      synth_base_mid_byte <= RST_BASE_MID;
    end else if (wr_mid) begin
      synth_base_mid_byte <= reg_req.wdata;
    end
  end

  // base low byte; the word changes byte by byte, host must tolerate it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      synth_base_low_byte <= RST_BASE_LOW;
    end else if (wr_low) begin
      synth_base_low_byte <= reg_req.wdata;
    end
  end

  // read select; unmapped offsets read zero
  // a read beside a write to the same offset sees the old value
  logic [7:0] read_mux;
  always_comb begin
    case (reg_req.addr)
      OFS_FILTER_CTRL: read_mux = filter_control;
      OFS_PKT_AUTO:    read_mux = pkt_auto;
      OFS_NODE_MATCH:  read_mux = node_match_value;
      OFS_SLOT_SEL:    read_mux = rf_slot_select;
      OFS_CTRL_IF:     read_mux = synth_control_if;
      OFS_CTRL_TRIM:   read_mux = synth_control_trim;
      OFS_BASE_HIGH:   read_mux = synth_base_high_byte;
      OFS_BASE_MID:    read_mux = synth_base_mid_byte;
      OFS_BASE_LOW:    read_mux = synth_base_low_byte;
      default:         read_mux = 8'h00;
    endcase
  end

  // frequency arithmetic, all in base-word units
  wire [WORD_W-1:0] base_word = {synth_base_high_byte, synth_base_mid_byte, synth_base_low_byte};
  wire [7:0]        rf_slot_index = rf_slot_select;
  wire [4:0]        intermediate_offset_word = synth_control_if[4:0];
  wire signed [7:0] carrier_trim = synth_control_trim;
  // spacing product is kept full width; overflow past 24 bits wraps like the word
  wire [SPACING_W+7:0] slot_offset = rf_slot_index * slot_spacing;
  wire [SUM_W-1:0]  trim_term = SUM_W'({{(SUM_W-8){carrier_trim[7]}}, carrier_trim}) << TRIM_SHIFT;
  wire [SUM_W-1:0]  if_term = SUM_W'(intermediate_offset_word) << IF_SHIFT;
  wire [SUM_W-1:0]  slot_term = SUM_W'(slot_offset);
  wire [SUM_W-1:0]  next_sum = SUM_W'(base_word) + slot_term + trim_term
                               - (rx_active ? if_term : SUM_W'(0));
  wire [WORD_W-1:0] next_synth_word = next_sum[WORD_W-1:0];

  // address filter
  wire filt_match;
  rfa_addr_filter u_filter (
    .filter_select (rfa_filter_t'(filter_control[1:0])),
    .node_addr     (node_match_value),
    .addr_byte     (rx_addr.addr_byte),
    .match         (filt_match)
  );

  // register port answer; data idles at zero outside a read
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata  <= reg_req.rd ? read_mux : 8'h00;
      reg_rvalid <= reg_req.rd;
    end
  end

  // modem and synthesizer copies, one cycle behind the registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      addr_ok                   <= 1'b0;
      addr_ok_valid             <= 1'b0;
      synth_word                <= 24'h000000;
      mixer_if_word             <= 5'h00;
      filter_select             <= 2'h0;
      packet_automation_control <= 8'h00;
    end else begin
      addr_ok                   <= rx_addr.valid & filt_match;
      addr_ok_valid             <= rx_addr.valid;
      synth_word                <= next_synth_word;
      mixer_if_word             <= intermediate_offset_word;
      filter_select             <= filter_control[1:0];
      packet_automation_control <= pkt_auto;
    end
  end

endmodule : rfa_synth_base_word_addr_cfg

// ==== rfa_pkg.sv ====
// rfa_pkg: offsets, reset values, field layouts and carrier types for the
// frequency and address configuration register group.
// assumes: an 8-bit register port decoded from the serial configuration port.
package rfa_pkg;

  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [5:0] OFS_FILTER_CTRL = 6'h07;
  localparam logic [5:0] OFS_PKT_AUTO    = 6'h08;
  localparam logic [5:0] OFS_NODE_MATCH  = 6'h09;
  localparam logic [5:0] OFS_SLOT_SEL    = 6'h0a;
  localparam logic [5:0] OFS_CTRL_IF     = 6'h0b;
  localparam logic [5:0] OFS_CTRL_TRIM   = 6'h0c;
  localparam logic [5:0] OFS_BASE_HIGH   = 6'h0d;
  localparam logic [5:0] OFS_BASE_MID    = 6'h0e;
  localparam logic [5:0] OFS_BASE_LOW    = 6'h0f;

  // reset values
  localparam logic [7:0] RST_FILTER_CTRL = 8'h00;
  localparam logic [7:0] RST_PKT_AUTO    = 8'h45;
  localparam logic [7:0] RST_NODE_MATCH  = 8'h00;
  localparam logic [7:0] RST_SLOT_SEL    = 8'h00;
  localparam logic [7:0] RST_CTRL_IF     = 8'h0f;
  localparam logic [7:0] RST_CTRL_TRIM   = 8'h00;
  localparam logic [7:0] RST_BASE_HIGH   = 8'h1e;
  localparam logic [7:0] RST_BASE_MID    = 8'hc4;
  localparam logic [7:0] RST_BASE_LOW    = 8'hec;

  // writable masks; masked bits read as zero
  localparam logic [7:0] MSK_FILTER_CTRL = 8'h03;
  localparam logic [7:0] MSK_PKT_AUTO    = 8'h77;
  localparam logic [7:0] MSK_CTRL_IF     = 8'h1f;
  localparam logic [7:0] MSK_BASE_HIGH   = 8'h3f;

  // broadcast destinations
  localparam logic [7:0] BCAST_ZERO = 8'h00;
  localparam logic [7:0] BCAST_ONES = 8'hff;

  // scaling into base-word units (step of base word is fxosc / 2^16)
  localparam int unsigned BASE_EXP   = 16;
  localparam int unsigned IF_EXP     = 10;
  localparam int unsigned TRIM_EXP   = 14;
  localparam int unsigned IF_SHIFT   = BASE_EXP - IF_EXP;
  localparam int unsigned TRIM_SHIFT = BASE_EXP - TRIM_EXP;
  localparam int unsigned WORD_W     = 24;
  localparam int unsigned SUM_W      = 26;

  typedef enum logic [1:0] {
    RFA_FILT_OFF   = 2'b00,
    RFA_FILT_NODE  = 2'b01,
    RFA_FILT_ZERO  = 2'b10,
    RFA_FILT_BOTH  = 2'b11
  } rfa_filter_t;

  typedef struct packed {
    logic [5:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } rfa_reg_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr_byte;
  } rfa_rx_addr_t;

endpackage : rfa_pkg

// ==== rfa_addr_filter.sv ====
// rfa_addr_filter: decides whether a received address byte is accepted.
// assumes: inputs steady for the cycle in which the caller samples match.
`timescale 1ns/10ps
module rfa_addr_filter (
  // configuration
  input  wire rfa_pkg::rfa_filter_t filter_select,
  input  wire logic [7:0]           node_addr,
  // received byte
  input  wire logic [7:0]           addr_byte,
  // verdict
  output logic                      match
);
  import rfa_pkg::*;

  wire hit_node = (addr_byte == node_addr);
  wire hit_zero = (addr_byte == BCAST_ZERO);
  wire hit_ones = (addr_byte == BCAST_ONES);

  always_comb begin
    case (filter_select)
      RFA_FILT_OFF:  match = 1'b1;
      RFA_FILT_NODE: match = hit_node;
      RFA_FILT_ZERO: match = hit_node | hit_zero;
      RFA_FILT_BOTH: match = hit_node | hit_zero | hit_ones;
      default:       match = 1'b0;
    endcase
  end

endmodule : rfa_addr_filter

// ==== rfa_synth_base_word_addr_cfg_chk.sv ====
// rfa_synth_base_word_addr_cfg_chk: port-level properties of the register group.
// assumes: bound onto rfa_synth_base_word_addr_cfg, one clock domain.
`timescale 1ns/10ps
module rfa_synth_base_word_addr_cfg_chk #(
  parameter int unsigned SPACING_W = 16
) (
  // clock and reset
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  // register port
  input wire rfa_pkg::rfa_reg_req_t reg_req,
  input wire logic [7:0]            reg_rdata,
  input wire logic                  reg_rvalid,
  // modem side
  input wire logic                  rx_active,
  input wire logic [SPACING_W-1:0]  slot_spacing,
  input wire rfa_pkg::rfa_rx_addr_t rx_addr,
  input wire logic                  addr_ok,
  input wire logic                  addr_ok_valid,
  input wire logic [23:0]           synth_word,
  input wire logic [4:0]            mixer_if_word,
  input wire logic [1:0]            filter_select
);
  import rfa_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire node_wr = reg_req.wr && reg_req.addr == OFS_NODE_MATCH;
  wire node_rd = reg_req.rd && !reg_req.wr && reg_req.addr == OFS_NODE_MATCH;
  property p_rd_answer; reg_req.rd |=> reg_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_node_back; node_wr ##1 !reg_req.wr ##1 node_rd |=> reg_rdata == $past(reg_req.wdata, 3); endproperty
  a_node_back: assert property (p_node_back) else $error("node value lost");
  // filter_select lags the live mode by one cycle, so it is read at the verdict
  property p_bc_ones; rx_addr.valid && rx_addr.addr_byte == BCAST_ONES ##1 filter_select == 2'b11 |-> addr_ok; endproperty
  a_bc_ones: assert property (p_bc_ones) else $error("all-ones broadcast refused");
  property p_bc_zero; rx_addr.valid && rx_addr.addr_byte == BCAST_ZERO ##1 filter_select[1] |-> addr_ok; endproperty
  a_bc_zero: assert property (p_bc_zero) else $error("zero broadcast refused");
  property p_filt_off; rx_addr.valid ##1 filter_select == 2'b00 |-> addr_ok && addr_ok_valid; endproperty
  a_filt_off: assert property (p_filt_off) else $error("byte refused with filter off");
  property p_if_bits; reg_rvalid && $past(reg_req.addr) == OFS_CTRL_IF |-> reg_rdata[7:5] == 3'b000; endproperty
  a_if_bits: assert property (p_if_bits) else $error("offset word upper bits set");
  property p_high_bits; reg_rvalid && $past(reg_req.addr) == OFS_BASE_HIGH |-> reg_rdata[7:6] == 2'b00; endproperty
  a_high_bits: assert property (p_high_bits) else $error("base word top bits set");
  // only rx changes here, so the word must drop by the offset term alone
  property p_rx_sub; $rose(rx_active) && $past(rst_n) && !$past(reg_req.wr) && $stable(slot_spacing)
    |=> synth_word == 24'($past(synth_word) - {mixer_if_word, 6'h00}); endproperty
  a_rx_sub: assert property (p_rx_sub) else $error("receive offset not applied");
  c_rx_rise: cover property ($rose(rx_active));
  c_bcast: cover property (rx_addr.valid && filter_select == 2'b11);
  c_read: cover property (reg_rvalid && reg_rdata != 8'h00);
endmodule : rfa_synth_base_word_addr_cfg_chk

// ==== rfa_host.sv ====
// rfa_host: host side of the register port, one request at a time.
// assumes: calls from the bench never overlap.
`timescale 1ns/10ps
module rfa_host (
  // clock
  input  wire logic             ref_clk,
  // register port
  output rfa_pkg::rfa_reg_req_t reg_req,
  input  wire logic [7:0]       reg_rdata,
  input  wire logic             reg_rvalid
);
  import rfa_pkg::*;
  initial reg_req = '0;
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk) reg_req <= '{a, 1'b1, 1'b0, d};
    @(posedge ref_clk) reg_req <= '0;
  endtask : wr
  // fixed one-cycle answer, so no wait loop is needed
  task automatic rd(input logic [5:0] a, output logic [8:0] q);
    @(posedge ref_clk) reg_req <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge ref_clk) reg_req <= '0;
    @(posedge ref_clk) q = {reg_rvalid, reg_rdata};
  endtask : rd
endmodule : rfa_host

// ==== rfa_synth_base_word_addr_cfg_tb.sv ====
// rfa_synth_base_word_addr_cfg_tb: random and corner checks of the register group.
// assumes: rfa_host speaks the register port.
`timescale 1ns/10ps
module rfa_synth_base_word_addr_cfg_tb;
  import rfa_pkg::*;
  logic ref_clk = 0, rst_n = 0, rx_active = 0, reg_rvalid, addr_ok, addr_ok_valid;
  logic [15:0] slot_spacing = '0;
  rfa_reg_req_t reg_req;
  rfa_rx_addr_t rx_addr = '0;
  logic [7:0] reg_rdata, packet_automation_control, d, bt [4];
  logic [8:0] q;
  logic [5:0] a;
  logic [23:0] synth_word;
  logic [4:0] mixer_if_word;
  logic [1:0] filter_select;
  logic [7:0] mem [64] = '{7: RST_FILTER_CTRL, 8: RST_PKT_AUTO, 11: RST_CTRL_IF, 13: RST_BASE_HIGH,
                           14: RST_BASE_MID, 15: RST_BASE_LOW, default: 8'h00};
  int failures = 0, n_tests = 0;
  always #50 ref_clk = ~ref_clk;
  rfa_host i_rfa_host (.ref_clk, .reg_req, .reg_rdata, .reg_rvalid);
  rfa_synth_base_word_addr_cfg i_rfa_synth_base_word_addr_cfg (.ref_clk(ref_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .rx_active(rx_active), .slot_spacing(slot_spacing), .rx_addr(rx_addr),
    .addr_ok(addr_ok), .addr_ok_valid(addr_ok_valid), .synth_word(synth_word), .mixer_if_word(mixer_if_word),
    .filter_select(filter_select), .packet_automation_control(packet_automation_control));
  function automatic logic [7:0] msk(input logic [5:0] x);
    case (x)
      OFS_FILTER_CTRL: return MSK_FILTER_CTRL;
      OFS_PKT_AUTO: return MSK_PKT_AUTO;
      OFS_CTRL_IF: return MSK_CTRL_IF;
      OFS_BASE_HIGH: return MSK_BASE_HIGH;
      default: return (x > 6'h08 && x < 6'h10) ? 8'hff : 8'h00;
    endcase
  endfunction : msk
  function automatic logic [23:0] exp_synth();
    return {mem[13], mem[14], mem[15]} + mem[10] * slot_spacing + {{14{mem[12][7]}}, mem[12], 2'b00}
      - (rx_active ? {mem[11][4:0], 6'h00} : 24'h0);
  endfunction : exp_synth
  function automatic logic ok_exp(input logic [7:0] b);
    return mem[7][1:0] == 2'b00 || b == mem[9] || (mem[7][1] && b == 8'h00) || (mem[7][1:0] == 2'b11 && b == 8'hff);
  endfunction : ok_exp
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  initial begin
    void'($urandom(32'h8011));
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 6; i < 17; i++) begin
      i_rfa_host.rd(6'(i), q);
      check("reset value", q, {1'b1, mem[i]});
    end
    // first sixteen rounds sweep every filter mode against every byte kind
    for (int i = 0; i < 240; i++) begin
      a = (i < 16) ? OFS_FILTER_CTRL : 6'($urandom_range(6, 16));
      d = (i < 16) ? 8'(i / 4) : 8'($urandom);
      i_rfa_host.wr(a, d);
      slot_spacing <= 16'($urandom);
      mem[a] = d & msk(a);
      i_rfa_host.rd(a, q);
      check("readback", q, {1'b1, mem[a]});
      rx_active <= 1'($urandom);
      bt = '{mem[9], 8'h00, 8'hff, 8'($urandom)};
      rx_addr <= '{1'b1, bt[i % 4]};
      @(posedge ref_clk) rx_addr <= '0;
      @(posedge ref_clk);
      check("filter verdict", {addr_ok_valid, addr_ok}, {1'b1, ok_exp(bt[i % 4])});
      check("synth word", synth_word, exp_synth());
      check("mixer word", mixer_if_word, mem[11][4:0]);
      check("filter select", filter_select, mem[7][1:0]);
      check("packet control", packet_automation_control, mem[8]);
    end
    // corner: low base high byte paired with an upper-band slot
    i_rfa_host.wr(OFS_BASE_HIGH, 8'h0a);
    mem[OFS_BASE_HIGH] = 8'h0a;
    d = 8'(101 + $urandom_range(0, 154));
    i_rfa_host.wr(OFS_SLOT_SEL, d);
    mem[OFS_SLOT_SEL] = d;
    @(posedge ref_clk);
    @(posedge ref_clk);
    check("paired synth word", synth_word, exp_synth());
    wrap_up();
  end
  initial begin
    #(100 * 5000);
    failures++;
    wrap_up();
  end
endmodule : rfa_synth_base_word_addr_cfg_tb
bind rfa_synth_base_word_addr_cfg rfa_synth_base_word_addr_cfg_chk #(.SPACING_W(SPACING_W)) i_rfa_synth_base_word_addr_cfg_chk (.ref_clk(ref_clk),
  .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .rx_active(rx_active),
  .slot_spacing(slot_spacing), .rx_addr(rx_addr), .addr_ok(addr_ok), .addr_ok_valid(addr_ok_valid),
  .synth_word(synth_word), .mixer_if_word(mixer_if_word), .filter_select(filter_select));
